// *** design/errd_decode.sv ***
module errd_decode
  import errd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  output logic fetch_ready,
  input wire logic irq_accept,
  input wire logic [15:0] irq_vector,
  input wire logic [15:0] stack_ptr,
  output logic [15:0] memory_address_bus,
  output logic mab_valid,
  output logic vector_shifted,
  output logic push_strobe,
  output logic [15:0] push_value,
  output logic push_refused,
  output logic instr_done,
  output logic [1:0] add_passes,
  output logic add_doubled,
  output logic reti_exec,
  output logic ret_history
);

  typedef enum logic [1:0] {
    ERRD_IDLE,
    ERRD_EXT,
    ERRD_EXEC
  } errd_state_t;

  errd_state_t state_reg;
  errd_state_t state_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic strobe_reg;
  logic strobe_next;
  logic [15:0] value_reg;
  logic [15:0] value_next;
  logic refused_reg;
  logic [1:0] passes_reg;
  logic doubled_reg;
  logic reti_reg;
  logic history_reg;
  logic history_next;
  logic pend_push_reg;
  logic pend_push_next;
  logic pend_hist_reg;
  logic pend_hist_next;

  // Decoder outputs for the word on the fetch port
  logic dec_is_push;
  logic dec_push_cg;
  logic dec_push_imm;
  logic dec_push_refused;
  logic [15:0] dec_cg_value;
  logic dec_add_match;
  logic dec_is_reti;
  logic dec_sets_history;
  logic [2:0] dec_cycles;

  errd_classify u_classify (
    .word(fetch_word),
    .is_push(dec_is_push),
    .push_cg(dec_push_cg),
    .push_imm(dec_push_imm),
    .push_refused(dec_push_refused),
    .cg_value(dec_cg_value),
    .add_match(dec_add_match),
    .is_reti(dec_is_reti),
    .sets_history(dec_sets_history),
    .cycles(dec_cycles)
  );

  errd_vector u_vector (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .irq_accept(irq_accept),
    .irq_vector(irq_vector),
    .stack_ptr(stack_ptr),
    .memory_address_bus(memory_address_bus),
    .mab_valid(mab_valid),
    .vector_shifted(vector_shifted)
  );

  // Handshake qualifiers
  wire take_word = fetch_valid && ready_reg;
  wire take_opcode = take_word && (state_reg == ERRD_IDLE);
  wire take_ext = take_word && (state_reg == ERRD_EXT);
  wire single_cycle = (dec_cycles == CYC_DEFAULT);

  // Doubled addition needs the history of the previous instruction
  wire double_hit = take_opcode && dec_add_match && history_reg;
  wire is_add = take_opcode && (fetch_word[14:12] == ADD_OPC_LOW);
  wire [1:0] passes_next = !is_add ? PASS_NONE :
                           double_hit ? PASS_TWO : PASS_ONE;

  // A push with a value to store, refused pushes excluded
  wire push_live = dec_is_push && !dec_push_refused;
  wire [15:0] first_value = dec_push_cg ? dec_cg_value : fetch_word;

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    strobe_next = 1'b0;
    value_next = value_reg;
    pend_push_next = pend_push_reg;
    pend_hist_next = pend_hist_reg;
    history_next = history_reg;
    case (state_reg)
      ERRD_IDLE:
      begin
        if (take_opcode)
        begin
          pend_push_next = push_live;
          pend_hist_next = dec_sets_history;
          value_next = first_value;
          if (single_cycle)
          begin
            done_next = 1'b1;
            strobe_next = push_live;
            history_next = dec_sets_history;
          end
          else if (dec_push_imm)
          begin
            state_next = ERRD_EXT;
            cnt_next = dec_cycles - 3'h1;
          end
          else
          begin
            state_next = ERRD_EXEC;
            cnt_next = dec_cycles - 3'h1;
            ready_next = 1'b0;
          end
        end
      end
      ERRD_EXT:
      begin
        if (take_ext)
        begin
          value_next = fetch_word;
          cnt_next = cnt_reg - 3'h1;
          state_next = ERRD_EXEC;
          ready_next = 1'b0;
        end
      end
      ERRD_EXEC:
      begin
        if (cnt_reg <= 3'h1)
        begin
          state_next = ERRD_IDLE;
          cnt_next = 3'h0;
          ready_next = 1'b1;
          done_next = 1'b1;
          strobe_next = pend_push_reg;
          history_next = pend_hist_reg;
        end
        else
        begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      default:
      begin
        state_next = ERRD_IDLE;
        cnt_next = 3'h0;
        ready_next = 1'b1;
      end
    endcase
  end

  // State and cycle count
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ERRD_IDLE;
      cnt_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Fetch handshake and completion pulses
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= ready_next;
      done_reg <= done_next;
      strobe_reg <= strobe_next;
    end
  end

  // Pushed value, reloaded from every opcode taken and again from the extension word of an immediate push
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_reg <= 16'h0000;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  // Effects held back until a multi-cycle instruction completes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_push_reg <= 1'b0;
      pend_hist_reg <= 1'b0;
    end
    else
    begin
      pend_push_reg <= pend_push_next;
      pend_hist_reg <= pend_hist_next;
    end
  end

  // One-instruction return history
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      history_reg <= 1'b0;
    end
    else
    begin
      history_reg <= history_next;
    end
  end

  // Refusal and return pulses, one cycle after the opcode is taken
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refused_reg <= 1'b0;
      reti_reg <= 1'b0;
    end
    else
    begin
      refused_reg <= take_opcode && dec_push_refused;
      reti_reg <= take_opcode && dec_is_reti;
    end
  end

  // Add pass count and doubled flag, one cycle after the opcode is taken
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      passes_reg <= PASS_NONE;
      doubled_reg <= 1'b0;
    end
    else
    begin
      passes_reg <= passes_next;
      doubled_reg <= double_hit;
    end
  end

  // Output drive
  assign fetch_ready = ready_reg;
  assign instr_done = done_reg;
  assign push_strobe = strobe_reg;
  assign push_value = value_reg;
  assign push_refused = refused_reg;
  assign add_passes = passes_reg;
  assign add_doubled = doubled_reg;
  assign reti_exec = reti_reg;
  assign ret_history = history_reg;

endmodule : errd_decode

// *** design/errd_pkg.sv ***
package errd_pkg;

  // Word and field widths
  localparam int WORD_W = 16;
  localparam int REG_W = 4;
  localparam int MODE_W = 2;
  localparam int CNT_W = 3;

  // Field positions in an instruction word
  localparam int DREG_LSB = 0;
  localparam int SRC_MODE_LSB = 4;
  localparam int BW_BIT = 6;
  localparam int DST_MODE_BIT = 7;
  localparam int SREG_LSB = 8;
  localparam int OPC_LSB = 12;

  // Single-operand push pattern in bits 15:7
  localparam logic [8:0] PUSH_PATTERN = 9'h024;
  localparam int PUSH_PAT_LSB = 7;

  // Two-operand ADD opcode in bits 15:12 with bit 15 free
  localparam logic [2:0] ADD_OPC_LOW = 3'h5;

  // Return encodings
  localparam logic [15:0] RET_WORD = 16'h4130;
  localparam logic [15:0] RETI_WORD = 16'h1300;
  localparam logic [15:0] RETI_ALT_WORD = 16'h1301;

  // Source addressing field values
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_IDX = 2'h1;
  localparam logic [1:0] MODE_IND = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // Register numbers
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;

  // Generated constants on the second generator register
  localparam logic [15:0] CG_ZERO = 16'h0000;
  localparam logic [15:0] CG_ONE = 16'h0001;
  localparam logic [15:0] CG_TWO = 16'h0002;
  localparam logic [15:0] CG_MINUS1 = 16'hffff;

  // Execution lengths in clock cycles
  localparam logic [2:0] CYC_PUSH_CG = 3'h3;
  localparam logic [2:0] CYC_PUSH_IMM = 3'h5;
  localparam logic [2:0] CYC_PUSH_OTHER = 3'h3;
  localparam logic [2:0] CYC_DEFAULT = 3'h1;

  // Wrong vector fetch
  localparam logic [15:0] VEC_FAULT_OFFSET = 16'h0020;
  localparam logic [7:0] SP_FAULT_PAGE = 8'h02;
  localparam int SP_FAULT_BIT = 5;

  // Add pass counts
  localparam logic [1:0] PASS_NONE = 2'h0;
  localparam logic [1:0] PASS_ONE = 2'h1;
  localparam logic [1:0] PASS_TWO = 2'h2;

  // Stack pointer lies in one of the four faulty 32-byte windows
  function automatic logic errd_sp_in_window(input logic [15:0] sp);
    errd_sp_in_window = (sp[15:8] == SP_FAULT_PAGE) && !sp[SP_FAULT_BIT];
  endfunction : errd_sp_in_window

endpackage : errd_pkg

// *** design/errd_classify.sv ***
module errd_classify
  import errd_pkg::*;
(
  input wire logic [15:0] word,
  output logic is_push,
  output logic push_cg,
  output logic push_imm,
  output logic push_refused,
  output logic [15:0] cg_value,
  output logic add_match,
  output logic is_reti,
  output logic sets_history,
  output logic [2:0] cycles
);

  // Field extraction
  wire [3:0] sreg = word[SREG_LSB +: REG_W];
  wire [3:0] dreg = word[DREG_LSB +: REG_W];
  wire [1:0] smode = word[SRC_MODE_LSB +: MODE_W];
  wire [3:0] preg = word[DREG_LSB +: REG_W];

  // Push classes
  assign is_push = (word[15:PUSH_PAT_LSB] == PUSH_PATTERN);
  assign push_refused = is_push && (preg == REG_SR) && smode[1];
  assign push_cg = is_push && (preg == REG_CG);
  assign push_imm = is_push && (preg == REG_PC) && (smode == MODE_AUTO);

  // Constants 0, 1, 2 and minus one only
  assign cg_value = (smode == MODE_REG) ? CG_ZERO :
                    (smode == MODE_IDX) ? CG_ONE :
                    (smode == MODE_IND) ? CG_TWO : CG_MINUS1;

  // Doubled-addition mask with register exclusions
  wire mask_hit = (word[14:12] == ADD_OPC_LOW) && !word[DST_MODE_BIT] &&
                  (smode == MODE_IND);
  wire sreg_ok = (sreg != REG_SR) && (sreg != REG_CG);
  wire dreg_ok = (dreg != REG_PC) && (dreg != REG_SR) && (dreg != REG_CG);
  assign add_match = mask_hit && sreg_ok && dreg_ok;

  // Both return-from-interrupt words execute as return; RET_WORD and the plain one arm history
  assign is_reti = (word == RETI_WORD) || (word == RETI_ALT_WORD);
  assign sets_history = (word == RET_WORD) || (word == RETI_WORD);

  // Execution length
  assign cycles = push_refused ? CYC_DEFAULT :
                  push_imm ? CYC_PUSH_IMM :
                  push_cg ? CYC_PUSH_CG :
                  is_push ? CYC_PUSH_OTHER : CYC_DEFAULT;

endmodule : errd_classify

// *** design/errd_vector.sv ***
module errd_vector
  import errd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic irq_accept,
  input wire logic [15:0] irq_vector,
  input wire logic [15:0] stack_ptr,
  output logic [15:0] memory_address_bus,
  output logic mab_valid,
  output logic vector_shifted
);

  logic [15:0] mab_reg;
  logic mab_valid_reg;
  logic shifted_reg;

  // Fault selection and the address that results
  wire fault = errd_sp_in_window(stack_ptr);
  wire [15:0] mab_next = fault ? (irq_vector - VEC_FAULT_OFFSET) : irq_vector;

  // Vector address drive, one cycle per acceptance
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mab_reg <= 16'h0000;
      mab_valid_reg <= 1'b0;
      shifted_reg <= 1'b0;
    end
    else
    begin
      mab_valid_reg <= irq_accept;
      shifted_reg <= irq_accept && fault;
      if (irq_accept)
      begin
        mab_reg <= mab_next;
      end
    end
  end

  assign memory_address_bus = mab_reg;
  assign mab_valid = mab_valid_reg;
  assign vector_shifted = shifted_reg;

endmodule : errd_vector

// *** bench/errd_pmem.sv ***
module errd_pmem
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [15:0] fetch_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] q[$];
  logic [15:0] last;
  logic hold;

  // Words waiting to be fetched, loaded by the bench
  task automatic put(input logic [15:0] w);
    q.push_back(w);
  endtask : put

  // Offers words in order, holds an untaken word, scrambles the idle bus
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      fetch_valid <= 1'b0;
      fetch_word <= 16'h0000;
      last = 16'h0000;
    end
    else
    begin
      hold = fetch_valid && !fetch_ready;
      if (fetch_valid && fetch_ready)
        last = q.pop_front();
      if (q.size() != 0 && (hold || !stall))
      begin
        fetch_valid <= 1'b1;
        fetch_word <= q[0];
      end
      else
      begin
        last = ~last;
        fetch_valid <= 1'b0;
        fetch_word <= last;
      end
    end
endmodule : errd_pmem

// *** bench/errd_chk.sv ***
module errd_chk
  import errd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic fetch_ready,
  input wire logic irq_accept,
  input wire logic [15:0] irq_vector,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] memory_address_bus,
  input wire logic mab_valid,
  input wire logic vector_shifted,
  input wire logic push_strobe,
  input wire logic [15:0] push_value,
  input wire logic push_refused,
  input wire logic instr_done,
  input wire logic [1:0] add_passes,
  input wire logic add_doubled,
  input wire logic reti_exec,
  input wire logic ret_history
);
  logic ext_reg;
  // Opcode take, stack window and doubled-add condition
  wire op = fetch_valid && fetch_ready && !ext_reg;
  wire win = stack_ptr[15:8] == 8'h02 && !stack_ptr[5];
  wire isadd = op && fetch_word[14:12] == 3'h5;
  wire dbl = !fetch_word[7] && fetch_word[5:4] == 2'h2 && ret_history
    && !(fetch_word[11:8] inside {4'h2, 4'h3}) && !(fetch_word[3:0] inside {4'h0, 4'h2, 4'h3});

  // Marks the extension word of an immediate push
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      ext_reg <= 1'b0;
    else if (fetch_valid && fetch_ready)
      ext_reg <= op && fetch_word == 16'h1230;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_mab_pulse: assert property (irq_accept |=> mab_valid)
    else $error("vector cycle missing");
  a_vec_low: assert property (irq_accept && win |=> vector_shifted &&
    memory_address_bus == $past(irq_vector) - 16'h0020) else $error("vector not lowered");
  a_vec_plain: assert property (irq_accept && !win |=> !vector_shifted &&
    memory_address_bus == $past(irq_vector)) else $error("vector moved outside window");
  a_push_cg: assert property (op && fetch_word == 16'h1213 |=> !fetch_ready ##1
    !fetch_ready ##1 instr_done && push_strobe && push_value == 16'h0001)
    else $error("constant push wrong");
  a_push_imm: assert property (op && fetch_word == 16'h1230 ##1 fetch_valid &&
    fetch_ready |=> !fetch_ready ##3 instr_done && push_strobe) else $error("imm push wrong");
  a_push_refuse: assert property (op && fetch_word[15:7] == PUSH_PATTERN &&
    fetch_word[3:0] == REG_SR && fetch_word[5] |=> push_refused && !push_strobe)
    else $error("push of 4 or 8 not refused");
  a_add_twice: assert property (isadd && dbl |=> add_passes == PASS_TWO && add_doubled)
    else $error("add not doubled");
  a_add_once: assert property (isadd && !dbl |=> add_passes == PASS_ONE && !add_doubled)
    else $error("add doubled wrongly");
  a_reti_both: assert property (op && fetch_word[15:1] == 15'h0980 |=> reti_exec)
    else $error("return from interrupt missed");
  a_hist_set: assert property (op && fetch_word == RET_WORD |=> ret_history)
    else $error("history not set");
  a_hist_alt: assert property (op && fetch_word == RETI_ALT_WORD |=> !ret_history)
    else $error("alternate return set history");
endmodule : errd_chk

bind errd_decode errd_chk chk (.*);

// *** bench/tb.sv ***
module tb
  import errd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, stall = 1'b0, slow = 1'b0, hist = 1'b0;
  logic fetch_valid, fetch_ready, irq_accept = 1'b0, mab_valid, vector_shifted;
  logic push_strobe, push_refused, instr_done, add_doubled, reti_exec, ret_history;
  logic [15:0] fetch_word, irq_vector = 16'h0000, stack_ptr = 16'h0000;
  logic [15:0] memory_address_bus, push_value, w;
  logic [1:0] add_passes;
  logic [15:0] exp_push[$];
  logic [1:0] exp_add[$];
  logic [16:0] exp_vec[$];
  int errors = 0, checks_done = 0, n_reti = 0, n_ref = 0, k;

  errd_decode uut (.*);
  errd_pmem pm (.*);

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  function automatic logic [1:0] add_exp(input logic [15:0] x, input logic h);
    return (h && !x[7] && x[5:4] == 2'h2 && !(x[11:8] inside {4'h2, 4'h3})
      && !(x[3:0] inside {4'h0, 4'h2, 4'h3})) ? PASS_TWO : PASS_ONE;
  endfunction : add_exp

  // Loads one instruction and records what it should produce
  task automatic emit(input logic [15:0] x);
    logic [15:0] ext;
    ext = 16'($urandom);
    pm.put(x);
    if (x[14:12] == 3'h5)
      exp_add.push_back(add_exp(x, hist));
    else if (x == 16'h1230)
    begin
      pm.put(ext);
      exp_push.push_back(ext);
    end
    else if (x[15:7] == 9'h024 && x[3:0] == 4'h3)
      exp_push.push_back(x[5:4] == 2'h3 ? 16'hffff : {14'h0000, x[5:4]});
    else if (x[15:7] == 9'h024)
      n_ref++;
    if (x[15:1] == 15'h0980)
      n_reti++;
    hist = x == RET_WORD || x == RETI_WORD;
  endtask : emit

  // Runs the loaded program out and settles the counts
  task automatic drain(input string nm);
    k = 0;
    while ((pm.q.size() != 0 || !fetch_ready) && k < 5000)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    #1; // Past the compare edge, so no vector is half counted
    chk("drain", 17'h0, 17'(k == 5000));
    chk("pushes left", 17'h0, 17'(exp_push.size()));
    chk("adds left", 17'h0, 17'(exp_add.size()));
    chk("returns left", 17'h0, 17'(n_reti));
    chk("refusals left", 17'h0, 17'(n_ref));
    chk("vectors left", 17'h0, 17'(exp_vec.size()));
    $display("test %s done", nm);
  endtask : drain

  // Random interrupts, stack pointer and fetch stalls
  always @(posedge clk_sys)
    if (rst_n)
    begin
      if (irq_accept)
        exp_vec.push_back((stack_ptr[15:8] == 8'h02 && !stack_ptr[5]) ?
          {1'b1, irq_vector - 16'h0020} : {1'b0, irq_vector});
      irq_accept <= $urandom % 5 == 0;
      irq_vector <= 16'($urandom);
      stack_ptr <= {($urandom % 2) ? 8'h02 : 8'($urandom), 8'($urandom)};
      stall <= slow && $urandom % 3 == 0;
    end

  // Compares results as they appear
  always @(negedge clk_sys)
    if (rst_n)
    begin
      if (push_strobe !== 1'b0)
        chk("push value", exp_push.pop_front(), push_value);
      if (add_passes !== 2'h0)
        chk("add passes", exp_add.pop_front(), add_passes);
      if (mab_valid !== 1'b0)
        chk("vector", exp_vec.pop_front(), {vector_shifted, memory_address_bus});
      if (reti_exec !== 1'b0)
        n_reti--;
      if (push_refused !== 1'b0)
        n_ref--;
    end

  initial
  begin
    #200000;
    errors++;
    results();
  end

  initial
  begin
    void'($urandom(32'h6d1365b3));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    emit(RET_WORD);
    emit(16'h5a2b);
    emit(RETI_WORD);
    emit(16'h5a20);
    emit(RETI_ALT_WORD);
    emit(16'h5a2b);
    emit(RET_WORD);
    emit(16'h522b);
    emit(RETI_WORD);
    emit(16'h5a21);
    for (int m = 0; m < 4; m++)
      emit({10'h048, 2'(m), 4'h3});
    emit(16'h1230);
    emit(16'h1222);
    emit(16'h1232);
    emit(RET_WORD);
    emit(16'h1213);
    drain("corner");
    slow = 1'b1;
    @(negedge clk_sys);
    for (int i = 0; i < 300; i++)
    begin
      w = 16'($urandom);
      w[14:12] = 3'h5;
      if (w[9])
      begin
        w[7] = 1'b0;
        w[5:4] = 2'h2;
      end
      case ($urandom % 8)
        0: emit(RET_WORD);
        1: emit(RETI_WORD);
        2: emit(RETI_ALT_WORD);
        3: emit({10'h048, 2'($urandom), 4'h3});
        4: emit(16'h1230);
        5: emit({10'h048, 1'b1, 1'($urandom), 4'h2});
        default: emit(w);
      endcase
    end
    drain("random");
    results();
  end
endmodule : tb
